/* File: rtl/pef_event_flags.sv */
// event flags, masks and interrupt of the power-management device
`include "pef_defines.svh"

module pef_event_flags (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // register port from the serial interface
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // battery comparator enable from charger control register
    input  wire logic       comparator_enable,
    // charger monitor levels (asynchronous)
    input  wire logic       thermistor_too_hot,
    input  wire logic       thermistor_too_cold,
    input  wire logic       input_overvoltage,
    input  wire logic       safety_timer_fault,
    input  wire logic       charging_in_progress,
    input  wire logic       charger_input_good,
    input  wire logic       battery_comparator,
    input  wire logic       thermal_regulation_active,
    // charger state machine indications (same clock)
    input  wire logic       charger_sleep_state,
    input  wire logic       charger_reset_state,
    input  wire logic       charger_idle_state,
    input  wire logic       charger_precharge_state,
    input  wire logic       charger_main_charge_state,
    input  wire logic       charger_linear_state,
    input  wire logic       charger_fault_state,
    input  wire logic       charger_suspend_state,
    // pin and power levels (asynchronous)
    input  wire logic       general_pin_0_change,
    input  wire logic       general_pin_1_change,
    input  wire logic       general_pin_2_change,
    input  wire logic       general_pin_3_change,
    input  wire logic       converter_output_not_good,
    input  wire logic       regulator_output_not_good,
    // debounced push-button (same clock)
    input  wire logic       pushbutton_status,
    // interrupt, active high
    output logic            irq
);

    pef_pkg::pef_state_t st_q;
    pef_pkg::pef_state_t st_d;

    logic [7:0] chg_raw;
    logic [7:0] chg_sync;
    logic [5:0] pin_raw;
    logic [5:0] pin_sync;
    logic [7:0] chg_now;
    logic [7:0] state_now;
    logic [7:0] pin_now;

    // edge detection: rising only, or either edge where selected
    function automatic logic [7:0] pef_edges(input logic [7:0] cur,
                                             input logic [7:0] prev,
                                             input logic [7:0] both);
        pef_edges = (cur & ~prev) | (both & ~cur & prev);
    endfunction

    // flag update: unmasked edges set, read clears, set wins over clear
    function automatic logic [7:0] pef_flag_next(input logic [7:0] flags,
                                                 input logic [7:0] set_bits,
                                                 input logic       clr);
        pef_flag_next = (clr ? `PEF_FLAGS_RESET : flags) | set_bits;
    endfunction

    assign chg_raw = {thermistor_too_hot, thermistor_too_cold, input_overvoltage,
                      safety_timer_fault, charging_in_progress, charger_input_good,
                      battery_comparator, thermal_regulation_active};

    assign pin_raw = {general_pin_3_change, general_pin_2_change,
                      general_pin_1_change, general_pin_0_change,
                      converter_output_not_good, regulator_output_not_good};

    pef_sync #(
        .WIDTH(8)
    ) u_chg_sync (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .async_in(chg_raw),
        .sync_out(chg_sync)
    );

    pef_sync #(
        .WIDTH(6)
    ) u_pin_sync (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .async_in(pin_raw),
        .sync_out(pin_sync)
    );

    // comparator level held low while the comparator is off
    always_comb begin
        chg_now = chg_sync;
        chg_now[`PEF_CHG_COMP_BIT] = chg_sync[`PEF_CHG_COMP_BIT] & comparator_enable;
    end

    assign state_now = {charger_sleep_state, charger_reset_state, charger_idle_state,
                        charger_precharge_state, charger_main_charge_state,
                        charger_linear_state, charger_fault_state,
                        charger_suspend_state};

    assign pin_now = {pin_sync, pushbutton_status, 1'b0};

    always_comb begin
        logic [7:0] chg_set;
        logic [7:0] state_set;
        logic [7:0] pin_set;
        logic       rd_chg;
        logic       rd_state;
        logic       rd_pin;
        chg_set   = '0;
        state_set = '0;
        pin_set   = '0;
        rd_chg    = reg_rd && (reg_addr == `PEF_ADDR_CHG_FLAGS);
        rd_state  = reg_rd && (reg_addr == `PEF_ADDR_STATE_FLAGS);
        rd_pin    = reg_rd && (reg_addr == `PEF_ADDR_PIN_FLAGS);
        st_d      = st_q;

        // priming count: synchronisers and previous levels settle first
        st_d.primed     = (st_q.primed == `PEF_PRIME_DONE) ? st_q.primed
                                                          : st_q.primed + 2'h1;
        st_d.chg_prev   = chg_now;
        st_d.state_prev = state_now;
        st_d.pin_prev   = pin_now;

        if (st_q.primed != 2'h0) begin
            chg_set   = pef_edges(chg_now, st_q.chg_prev, `PEF_CHG_BOTH_EDGES)
                        & ~st_q.chg_mask;
            state_set = pef_edges(state_now, st_q.state_prev, `PEF_STATE_BOTH_EDGES)
                        & ~st_q.state_mask;
            pin_set   = pef_edges(pin_now, st_q.pin_prev, `PEF_PIN_BOTH_EDGES)
                        & ~st_q.pin_mask & `PEF_PIN_FLAGS_USED;
        end
        // synchronised levels still show reset zeros: no false edge
        if (st_q.primed != `PEF_PRIME_DONE) begin
            chg_set = '0;
            pin_set = pin_set & `PEF_PIN_SAME_CLOCK;
        end
        // comparator event cannot set while the comparator is off
        if (!comparator_enable) begin
            chg_set[`PEF_CHG_COMP_BIT] = 1'b0;
        end

        st_d.chg_flags   = pef_flag_next(st_q.chg_flags, chg_set, rd_chg);
        st_d.state_flags = pef_flag_next(st_q.state_flags, state_set, rd_state);
        st_d.pin_flags   = pef_flag_next(st_q.pin_flags, pin_set, rd_pin)
                           & `PEF_PIN_FLAGS_USED;

        // mask writes
        if (reg_wr) begin
            unique case (reg_addr)
                `PEF_ADDR_CHG_MASK: begin
                    st_d.chg_mask = reg_wdata;
                end
                `PEF_ADDR_STATE_MASK: begin
                    st_d.state_mask = reg_wdata;
                end
                `PEF_ADDR_PIN_MASK: begin
                    st_d.pin_mask = (reg_wdata & `PEF_PIN_MASK_WRITABLE)
                                    | ~`PEF_PIN_MASK_WRITABLE;
                end
                default: begin
                end
            endcase
        end

        // read data, captured on the read strobe
        if (reg_rd) begin
            unique case (reg_addr)
                `PEF_ADDR_CHG_MASK:    st_d.rdata = st_q.chg_mask;
                `PEF_ADDR_STATE_MASK:  st_d.rdata = st_q.state_mask;
                `PEF_ADDR_PIN_MASK:    st_d.rdata = st_q.pin_mask;
                `PEF_ADDR_CHG_FLAGS:   st_d.rdata = st_q.chg_flags;
                `PEF_ADDR_STATE_FLAGS: st_d.rdata = st_q.state_flags;
                `PEF_ADDR_PIN_FLAGS:   st_d.rdata = st_q.pin_flags;
                default:               st_d.rdata = `PEF_UNMAPPED_READ;
            endcase
        end

        // interrupt from any flag still unmasked
        st_d.irq = |((st_d.chg_flags & ~st_d.chg_mask)
                     | (st_d.state_flags & ~st_d.state_mask)
                     | (st_d.pin_flags & ~st_d.pin_mask));
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_q.chg_mask    <= `PEF_MASK_RESET;
            st_q.state_mask  <= `PEF_MASK_RESET;
            st_q.pin_mask    <= `PEF_MASK_RESET;
            st_q.chg_flags   <= `PEF_FLAGS_RESET;
            st_q.state_flags <= `PEF_FLAGS_RESET;
            st_q.pin_flags   <= `PEF_FLAGS_RESET;
            st_q.chg_prev    <= 8'h00;
            st_q.state_prev  <= 8'h00;
            st_q.pin_prev    <= 8'h00;
            st_q.rdata       <= 8'h00;
            st_q.primed      <= 2'h0;
            st_q.irq         <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata = st_q.rdata;
    assign irq       = st_q.irq;

endmodule

/* File: rtl/pef_defines.svh */
// offsets, bit positions, reset values and edge selections of the event flag block
// Function
// - charger-state mask register at 0Eh, defaults ones
// - mask zero passes event, one suppresses it
// - pin/power mask at 0Fh, bit 0 read-only
// - charger flags at 10h, edge-set per event
// - charger flag set if unmasked, cleared by read
// - comparator event off while comparator disabled
// - charger-state flags at 11h, rising edges
// - state flag set if unmasked, cleared by read
// - pin/power flags at 12h, per-bit edge kinds
// - pin-change flags set on change, read clears
// - power-good flags set on drop, read clears
// - push-button flag set on change, read clears
// - flags reset zero; pin flag bit 0 zero
// - charger event mask at 0Dh, defaults ones
`ifndef PEF_DEFINES_SVH
`define PEF_DEFINES_SVH

`define PEF_ADDR_CHG_MASK    8'h0d
`define PEF_ADDR_STATE_MASK  8'h0e
`define PEF_ADDR_PIN_MASK    8'h0f
`define PEF_ADDR_CHG_FLAGS   8'h10
`define PEF_ADDR_STATE_FLAGS 8'h11
`define PEF_ADDR_PIN_FLAGS   8'h12

`define PEF_MASK_RESET       8'hff
`define PEF_FLAGS_RESET      8'h00
`define PEF_UNMAPPED_READ    8'h00

// bits of the pin/power mask that software may write
`define PEF_PIN_MASK_WRITABLE 8'hfe
// bits of the pin/power flag register that exist
`define PEF_PIN_FLAGS_USED    8'hfe

// flags set on both edges (others on rising edge only)
`define PEF_CHG_BOTH_EDGES    8'h0c
`define PEF_STATE_BOTH_EDGES  8'h00
`define PEF_PIN_BOTH_EDGES    8'hf2

// battery comparator flag position
`define PEF_CHG_COMP_BIT      1

// pin/power flags fed from the same clock (push-button)
`define PEF_PIN_SAME_CLOCK    8'h02
// edges after reset before synchronised levels may flag
`define PEF_PRIME_DONE        2'h3

`endif

/* File: rtl/pef_pkg.sv */
// types of the event flag block
package pef_pkg;

    typedef struct packed {
        logic [7:0] chg_mask;
        logic [7:0] state_mask;
        logic [7:0] pin_mask;
        logic [7:0] chg_flags;
        logic [7:0] state_flags;
        logic [7:0] pin_flags;
        logic [7:0] chg_prev;
        logic [7:0] state_prev;
        logic [7:0] pin_prev;
        logic [7:0] rdata;
        logic [1:0] primed;
        logic       irq;
    } pef_state_t;

endpackage

/* File: rtl/pef_sync.sv */
// two flip-flop synchroniser for status levels from outside the clock domain
module pef_sync #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             rst_n,
    // levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule

/* File: verification/pef_event_props.sv */
// checker of the event flag block
`include "pef_defines.svh"
module pef_event_props (
    // clock, reset, register port
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // events and interrupt
    input wire logic       charger_sleep_state,
    input wire logic       pushbutton_status,
    input wire logic       irq
);
    logic [7:0] cm_q, sm_q, pm_q, sel;
    logic       is_m;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // shadow of the three mask registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cm_q <= 8'hff;
            sm_q <= 8'hff;
            pm_q <= 8'hff;
        end else if (reg_wr) begin
            if (reg_addr == `PEF_ADDR_CHG_MASK) cm_q <= reg_wdata;
            if (reg_addr == `PEF_ADDR_STATE_MASK) sm_q <= reg_wdata;
            if (reg_addr == `PEF_ADDR_PIN_MASK) pm_q <= reg_wdata | 8'h01;
        end
    end
    assign is_m = reg_addr >= `PEF_ADDR_CHG_MASK && reg_addr <= `PEF_ADDR_PIN_MASK;
    assign sel = reg_addr == `PEF_ADDR_CHG_MASK ? cm_q :
                 reg_addr == `PEF_ADDR_STATE_MASK ? sm_q : pm_q;
    sequence s_reread;
        reg_rd && reg_addr == `PEF_ADDR_STATE_FLAGS && !$rose(charger_sleep_state)
            ##1 reg_rd && reg_addr == `PEF_ADDR_STATE_FLAGS;
    endsequence
    sequence s_sleep_rise;
        !sm_q[7] && $rose(charger_sleep_state) && $past(rst_n) && !reg_wr;
    endsequence
    a_irq_after_reset: assert property ($rose(rst_n) |-> !irq)
        else $error("irq high right after reset");
    a_mask_read_back: assert property (reg_rd && is_m |=> reg_rdata == $past(sel))
        else $error("mask read differs from written value");
    a_mask_bit_fixed: assert property (reg_rd && reg_addr == `PEF_ADDR_PIN_MASK |=> reg_rdata[0])
        else $error("pin mask bit 0 not one");
    a_pin_bit_zero: assert property (reg_rd && reg_addr == `PEF_ADDR_PIN_FLAGS |=> !reg_rdata[0])
        else $error("pin flag bit 0 not zero");
    a_masked_quiet: assert property (((cm_q & sm_q & pm_q) == 8'hff) [*2] |-> !irq)
        else $error("irq high with all events masked");
    a_state_sets_irq: assert property (s_sleep_rise |=> irq)
        else $error("unmasked state rise gave no irq");
    a_button_sets_irq: assert property ($changed(pushbutton_status) && !pm_q[1] && $past(rst_n) && !reg_wr |=> irq)
        else $error("unmasked button change gave no irq");
    a_read_clears_flag: assert property (s_reread |=> !reg_rdata[7])
        else $error("state flag not cleared by read");
endmodule
bind pef_event_flags pef_event_props u_props (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .charger_sleep_state(charger_sleep_state), .pushbutton_status(pushbutton_status), .irq(irq));

/* File: verification/pef_host.sv */
// host model driving the register port of the event flag block
module pef_host (
    // clock
    input  wire logic       mclk,
    // register port
    output logic      [7:0] reg_addr = 8'h00,
    output logic            reg_wr = 1'b0,
    output logic      [7:0] reg_wdata = 8'h00,
    output logic            reg_rd = 1'b0,
    input  wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge mclk);
        reg_wr = 1'b0;
    endtask
    // two = back-to-back second read of the same address
    task automatic rd(input logic [7:0] a, input bit two, output logic [7:0] d0, d1);
        @(negedge mclk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge mclk);
        d0 = reg_rdata;
        if (two) @(negedge mclk);
        reg_rd = 1'b0;
        d1 = reg_rdata;
    endtask
endmodule

/* File: verification/test_pef_event_flags.sv */
// self-checking bench of the event flag block
`include "pef_defines.svh"
module test_pef_event_flags;
    timeunit 1ns;
    timeprecision 1ns;
    logic       mclk = 1'b0;
    logic       rst_n = 1'b0;
    logic       cmp_en = 1'b1;
    logic [7:0] ch = 8'h00, st = 8'h00, pn = 8'h00, a, wd, rdat, d0, d1;
    logic       wr, rd, irq;
    int         fail_count = 0, cmp_count = 0;
    always #50 mclk = ~mclk;
    pef_host host (.mclk(mclk), .reg_addr(a), .reg_wr(wr), .reg_wdata(wd), .reg_rd(rd),
        .reg_rdata(rdat));
    pef_event_flags uut (.mclk(mclk), .rst_n(rst_n), .reg_addr(a), .reg_wr(wr), .reg_wdata(wd),
        .reg_rd(rd), .reg_rdata(rdat), .comparator_enable(cmp_en), .irq(irq),
        .thermistor_too_hot(ch[7]), .thermistor_too_cold(ch[6]), .input_overvoltage(ch[5]),
        .safety_timer_fault(ch[4]), .charging_in_progress(ch[3]), .charger_input_good(ch[2]),
        .battery_comparator(ch[1]), .thermal_regulation_active(ch[0]),
        .charger_sleep_state(st[7]), .charger_reset_state(st[6]), .charger_idle_state(st[5]),
        .charger_precharge_state(st[4]), .charger_main_charge_state(st[3]),
        .charger_linear_state(st[2]), .charger_fault_state(st[1]), .charger_suspend_state(st[0]),
        .general_pin_3_change(pn[7]), .general_pin_2_change(pn[6]), .general_pin_1_change(pn[5]),
        .general_pin_0_change(pn[4]), .converter_output_not_good(pn[3]),
        .regulator_output_not_good(pn[2]), .pushbutton_status(pn[1]));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rdc(input logic [7:0] ad, input logic [7:0] e);
        host.rd(ad, 1'b0, d0, d1);
        chk($sformatf("reg %h", ad), e, d0);
    endtask
    task automatic ick(input logic e);
        chk("irq", {7'h00, e}, {7'h00, irq});
    endtask
    // async levels reach the flags three edges after a change
    task automatic ev(input logic [7:0] c, input logic [7:0] s, input logic [7:0] p);
        ch = c;
        st = s;
        pn = p;
        repeat (4) @(negedge mclk);
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge mclk);
        fail_count++;
        complete_run();
    end
    initial begin
        repeat (20) @(negedge mclk);
        rst_n = 1'b1;
        for (int i = 13; i <= 18; i++) rdc(i[7:0], i < 16 ? 8'hff : 8'h00);
        rdc(8'h20, `PEF_UNMAPPED_READ);
        ev(8'hff, 8'hff, 8'hfe);
        ick(1'b0);
        ev(8'h00, 8'h00, 8'h00);
        for (int i = 16; i <= 18; i++) rdc(i[7:0], 8'h00);
        host.wr(`PEF_ADDR_CHG_MASK, 8'h00);
        host.wr(`PEF_ADDR_STATE_MASK, 8'h00);
        host.wr(`PEF_ADDR_PIN_MASK, 8'h00);
        rdc(`PEF_ADDR_PIN_MASK, 8'h01);
        ev(8'h00, 8'hff, 8'h00);
        ick(1'b1);
        host.rd(`PEF_ADDR_STATE_FLAGS, 1'b1, d0, d1);
        chk("state flags", 8'hff, d0);
        chk("state reread", 8'h00, d1);
        ick(1'b0);
        ev(8'h00, 8'h00, 8'h00);
        rdc(`PEF_ADDR_STATE_FLAGS, 8'h00);
        ev(8'hff, 8'h00, 8'h00);
        rdc(`PEF_ADDR_CHG_FLAGS, 8'hff);
        ev(8'h00, 8'h00, 8'h00);
        rdc(`PEF_ADDR_CHG_FLAGS, 8'h0c);
        host.wr(`PEF_ADDR_CHG_FLAGS, 8'hff);
        rdc(`PEF_ADDR_CHG_FLAGS, 8'h00);
        cmp_en = 1'b0;
        ev(8'h02, 8'h00, 8'h00);
        rdc(`PEF_ADDR_CHG_FLAGS, 8'h00);
        cmp_en = 1'b1;
        ev(8'h02, 8'h00, 8'h00);
        rdc(`PEF_ADDR_CHG_FLAGS, 8'h02);
        ev(8'h00, 8'h00, 8'h00);
        ev(8'h00, 8'h00, 8'hfe);
        rdc(`PEF_ADDR_PIN_FLAGS, 8'hfe);
        ev(8'h00, 8'h00, 8'h00);
        rdc(`PEF_ADDR_PIN_FLAGS, 8'hf2);
        host.wr(`PEF_ADDR_STATE_MASK, 8'h80);
        ev(8'h00, 8'hff, 8'h00);
        rdc(`PEF_ADDR_STATE_FLAGS, 8'h7f);
        ev(8'h00, 8'h00, 8'h00);
        // leave flags pending so that reset has something to clear
        ev(8'h00, 8'hff, 8'h00);
        ick(1'b1);
        rst_n = 1'b0;
        @(negedge mclk);
        rst_n = 1'b1;
        ick(1'b0);
        rdc(`PEF_ADDR_STATE_MASK, 8'hff);
        rdc(`PEF_ADDR_STATE_FLAGS, 8'h00);
        complete_run();
    end
endmodule
